//--- core/rail_good_pkg.sv
// constants for the rail-good status, rail-good control and buck-one voltage registers
package rail_good_pkg;
    // register offsets on the serial register bus
    localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h0B;
    localparam logic [7:0] ADDR_RAIL_GOOD_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_RAIL_GOOD_CONTROL = 8'h0D;
    localparam logic [7:0] ADDR_BUCK_ONE_VOLTAGE_CONTROL = 8'h0E;

    // unlock key handling
    localparam logic [7:0] UNLOCK_VALUE = 8'h7D;
    localparam logic [7:0] KEY_CLEAR = 8'h00;

    // status bit positions
    localparam int unsigned STAT_LINEAR_THREE = 6;
    localparam int unsigned STAT_LINEAR_FOUR = 5;
    localparam int unsigned STAT_BUCK_ONE = 4;
    localparam int unsigned STAT_BUCK_TWO = 3;
    localparam int unsigned STAT_BUCK_THREE = 2;
    localparam int unsigned STAT_LINEAR_ONE = 1;
    localparam int unsigned STAT_LINEAR_TWO = 0;
    localparam int unsigned STAT_RESERVED = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // control register layout
    localparam int unsigned CTL_LINEAR_ONE_MASK = 3;
    localparam int unsigned CTL_LINEAR_TWO_MASK = 2;
    localparam int unsigned CTL_DELAY_MSB = 1;
    localparam int unsigned CTL_DELAY_LSB = 0;
    localparam int unsigned CTL_WIDTH = 4;
    localparam logic [7:0] CONTROL_RESET = 8'h0C;

    // buck-one register layout
    localparam int unsigned BUCK_EXT_BIT = 7;
    localparam int unsigned BUCK_CODE_MSB = 5;
    localparam logic [5:0] BUCK_CODE_DEFAULT = 6'h0E;

    // raw rail input count: seven good flags and two switch flags
    localparam int unsigned RAW_COUNT = 9;

    // timing: clock period and one millisecond, both in ns
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MS_NS = 1_000_000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;

    // rail-good delay choices in ms
    localparam logic [8:0] DELAY_MS_SEL0 = 9'h014;
    localparam logic [8:0] DELAY_MS_SEL1 = 9'h064;
    localparam logic [8:0] DELAY_MS_SEL2 = 9'h0C8;
    localparam logic [8:0] DELAY_MS_SEL3 = 9'h190;

    // decode of the two-bit delay select to milliseconds
    function automatic logic [8:0] delay_ms(input logic [1:0] sel);
        logic [8:0] ms;
        ms = DELAY_MS_SEL0;
        unique case (sel)
            2'h0: ms = DELAY_MS_SEL0;
            2'h1: ms = DELAY_MS_SEL1;
            2'h2: ms = DELAY_MS_SEL2;
            2'h3: ms = DELAY_MS_SEL3;
        endcase
        return ms;
    endfunction
endpackage

//--- core/good_delay_timer.sv
// rail-good pin qualification timer
`timescale 1ns/100ps
module good_delay_timer #(
    parameter int unsigned ms_tick_cycles = rail_good_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // qualification inputs
    input wire logic all_good,
    input wire logic [1:0] delay_select,
    // qualified output
    output logic good_out
);
    typedef enum logic [0:0] {
        ST_WAIT = 1'b0,
        ST_GOOD = 1'b1
    } timer_state_t;

    typedef struct packed {
        timer_state_t st;
        logic [23:0] div;
        logic [8:0] ms;
    } timer_t;

    localparam logic [23:0] TICK_LAST = 24'(ms_tick_cycles - 1);

    timer_t q;
    timer_t d;

    // restart on any drop, count whole ms while good, release after delay
    always_comb begin
        d = q;
        if (!all_good) begin
            d.st = ST_WAIT;
            d.div = '0;
            d.ms = '0;
        end else begin
            unique case (q.st)
                ST_WAIT: begin
                    if (q.ms >= rail_good_pkg::delay_ms(delay_select)) begin
                        d.st = ST_GOOD;
                    end else if (q.div == TICK_LAST) begin
                        d.div = '0;
                        d.ms = q.ms + 9'h001;
                    end else begin
                        d.div = q.div + 24'h00_0001;
                    end
                end
                ST_GOOD: d = q;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (srst) begin
            q <= '{st: ST_WAIT, div: '0, ms: '0};
        end else begin
            q <= d;
        end
    end

    assign good_out = (q.st == ST_GOOD);
endmodule

//--- core/rail_good_regs.sv
// rail-good status, rail-good control, buck-one voltage and unlock key registers
`timescale 1ns/100ps
// Notes on behaviour
// R1 - status bits 4,3,2 show each buck converter in regulation, else 0
// R2 - status bits 1,0 show linear one and two in regulation, else 0
// R3 - status bits 6,5 show linear three/four regulating or used as switch
// R4 - status register read-only, bit 7 reads 0, all bits reset to 0
// R5 - control bit 3 clear lets low linear one status pull pin low
// R6 - control bit 2 clear lets low linear two status pull pin low
// R7 - control bits 1:0 pick pin delay 20, 100, 200 or 400 ms
// R8 - control register resets to 0x0C, upper four bits read zero
// R9 - control and buck-one registers written only right after unlocking
// R10 - buck-one bit 7 picks external adjust over register code, resets 0
// R11 - buck-one bits 5:0 hold the six-bit output voltage code
// R12 - buck-one code reset value is variant dependent, bit 6 reads zero
// R13 - writing 0x7D to key register allows one protected write next
// R14 - key register clears to zero after the following bus transaction
// R15 - pin high after unmasked rails good for delay, low at once on drop
module rail_good_regs #(
    parameter int unsigned ms_tick_cycles = rail_good_pkg::MS_CYCLES,
    parameter logic [5:0] buck_one_reset_code = rail_good_pkg::BUCK_CODE_DEFAULT
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // decoded serial-bus register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic xfer_end,
    // rail regulation flags from the analog side
    input wire logic buck_one_good,
    input wire logic buck_two_good,
    input wire logic buck_three_good,
    input wire logic linear_one_good,
    input wire logic linear_two_good,
    input wire logic linear_three_good,
    input wire logic linear_four_good,
    input wire logic linear_three_is_switch,
    input wire logic linear_four_is_switch,
    // outputs to the pin and the buck-one converter
    output logic rail_good_output,
    output logic buck_one_external_adjust,
    output logic [5:0] buck_one_voltage_code
);
    localparam int unsigned N = rail_good_pkg::RAW_COUNT;

    typedef struct packed {
        logic [N-1:0] sync1;
        logic [N-1:0] sync2;
        logic [N-1:0] sync3;
        logic [N-1:0] filt;
        logic [7:0] status;
        logic [rail_good_pkg::CTL_WIDTH-1:0] ctl;
        logic buck_ext;
        logic [5:0] buck_code;
        logic [7:0] key;
        logic key_fresh;
        logic [7:0] rdata;
    } regs_t;

    regs_t q;
    regs_t d;
    logic [N-1:0] raw;
    logic unlocked;
    logic all_good;

    // raw rail flags gathered into one vector
    assign raw = {linear_four_is_switch, linear_three_is_switch, linear_four_good,
                  linear_three_good, buck_one_good, buck_two_good, buck_three_good,
                  linear_one_good, linear_two_good};

    // protected write allowed only in the transaction after the key one
    assign unlocked = (q.key == rail_good_pkg::UNLOCK_VALUE) && !q.key_fresh; // [R9] [R13]

    // unmasked rails must all be good for the pin
    assign all_good = q.status[rail_good_pkg::STAT_BUCK_ONE]
        && q.status[rail_good_pkg::STAT_BUCK_TWO]
        && q.status[rail_good_pkg::STAT_BUCK_THREE]
        && q.status[rail_good_pkg::STAT_LINEAR_THREE]
        && q.status[rail_good_pkg::STAT_LINEAR_FOUR]
        && (q.status[rail_good_pkg::STAT_LINEAR_ONE]
            || q.ctl[rail_good_pkg::CTL_LINEAR_ONE_MASK]) // [R5]
        && (q.status[rail_good_pkg::STAT_LINEAR_TWO]
            || q.ctl[rail_good_pkg::CTL_LINEAR_TWO_MASK]); // [R6]

    // synchroniser, register writes, key handling and read mux
    always_comb begin
        d = q;
        d.sync1 = raw;
        d.sync2 = q.sync1;
        d.sync3 = q.sync2;
        for (int i = 0; i < N; i++) begin
            if (q.sync2[i] == q.sync3[i]) begin
                d.filt[i] = q.sync3[i];
            end
        end
        d.status = '0; // [R4]
        d.status[rail_good_pkg::STAT_BUCK_ONE] = q.filt[4]; // [R1]
        d.status[rail_good_pkg::STAT_BUCK_TWO] = q.filt[3]; // [R1]
        d.status[rail_good_pkg::STAT_BUCK_THREE] = q.filt[2]; // [R1]
        d.status[rail_good_pkg::STAT_LINEAR_ONE] = q.filt[1]; // [R2]
        d.status[rail_good_pkg::STAT_LINEAR_TWO] = q.filt[0]; // [R2]
        d.status[rail_good_pkg::STAT_LINEAR_THREE] = q.filt[5] | q.filt[7]; // [R3]
        d.status[rail_good_pkg::STAT_LINEAR_FOUR] = q.filt[6] | q.filt[8]; // [R3]
        if (reg_wr) begin
            if (reg_addr == rail_good_pkg::ADDR_UNLOCK_KEY) begin
                d.key = reg_wdata; // [R13]
                d.key_fresh = 1'b1;
            end else if (reg_addr == rail_good_pkg::ADDR_RAIL_GOOD_CONTROL && unlocked) begin
                d.ctl = reg_wdata[rail_good_pkg::CTL_WIDTH-1:0]; // [R8] [R9]
                d.key = rail_good_pkg::KEY_CLEAR; // [R13]
            end else if (reg_addr == rail_good_pkg::ADDR_BUCK_ONE_VOLTAGE_CONTROL
                         && unlocked) begin
                d.buck_ext = reg_wdata[rail_good_pkg::BUCK_EXT_BIT]; // [R10] [R9]
                d.buck_code = reg_wdata[rail_good_pkg::BUCK_CODE_MSB:0]; // [R11]
                d.key = rail_good_pkg::KEY_CLEAR; // [R13]
            end
        end
        if (xfer_end) begin
            if (d.key_fresh) begin
                d.key_fresh = 1'b0;
            end else begin
                d.key = rail_good_pkg::KEY_CLEAR; // [R14]
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                rail_good_pkg::ADDR_UNLOCK_KEY: d.rdata = q.key;
                rail_good_pkg::ADDR_RAIL_GOOD_STATUS: d.rdata = q.status; // [R4]
                rail_good_pkg::ADDR_RAIL_GOOD_CONTROL: d.rdata = {4'h0, q.ctl}; // [R8]
                rail_good_pkg::ADDR_BUCK_ONE_VOLTAGE_CONTROL:
                    d.rdata = {q.buck_ext, 1'b0, q.buck_code}; // [R12]
                default: d.rdata = 8'h00;
            endcase
        end
        if (srst) begin
            d = '0;
            d.status = rail_good_pkg::STATUS_RESET; // [R4]
            d.ctl = rail_good_pkg::CONTROL_RESET[rail_good_pkg::CTL_WIDTH-1:0]; // [R8]
            d.buck_code = buck_one_reset_code; // [R12]
            d.key = rail_good_pkg::KEY_CLEAR;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        q <= d;
    end

    // pin qualification delay
    good_delay_timer #(
        .ms_tick_cycles(ms_tick_cycles)
    ) u_timer (
        .clock(clock),
        .srst(srst),
        .all_good(all_good),
        .delay_select(q.ctl[rail_good_pkg::CTL_DELAY_MSB:rail_good_pkg::CTL_DELAY_LSB]), // [R7]
        .good_out(rail_good_output) // [R15]
    );

    assign reg_rdata = q.rdata;
    assign buck_one_external_adjust = q.buck_ext;
    assign buck_one_voltage_code = q.buck_code;

    // cycles that the unmasked rails have been good without a break
    logic [31:0] good_run_q;
    always_ff @(posedge clock) begin
        if (srst || !all_good) begin
            good_run_q <= '0;
        end else if (good_run_q != 32'hFFFF_FFFF) begin
            good_run_q <= good_run_q + 32'h0000_0001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    property p_buck_one_status;
        (buck_one_good && !srst) [*5] |=> q.status[rail_good_pkg::STAT_BUCK_ONE];
    endproperty
    a_buck_one_status: assert property (p_buck_one_status) // [R1]
        else $error("buck one status not set after stable good input");

    property p_linear_one_status;
        (!linear_one_good && !srst) [*5] |=> !q.status[rail_good_pkg::STAT_LINEAR_ONE];
    endproperty
    a_linear_one_status: assert property (p_linear_one_status) // [R2]
        else $error("linear one status not cleared after stable low input");

    property p_switch_status;
        (linear_three_is_switch && !srst) [*5] |=> q.status[rail_good_pkg::STAT_LINEAR_THREE];
    endproperty
    a_switch_status: assert property (p_switch_status) // [R3]
        else $error("linear three as switch does not read good");

    property p_status_reserved;
        reg_rd && reg_addr == rail_good_pkg::ADDR_RAIL_GOOD_STATUS
            |=> !reg_rdata[rail_good_pkg::STAT_RESERVED];
    endproperty
    a_status_reserved: assert property (p_status_reserved) // [R4]
        else $error("reserved status bit read as one");

    property p_mask_one;
        !q.ctl[rail_good_pkg::CTL_LINEAR_ONE_MASK] && !q.status[rail_good_pkg::STAT_LINEAR_ONE]
            |=> !rail_good_output;
    endproperty
    a_mask_one: assert property (p_mask_one) // [R5]
        else $error("unmasked low linear one did not pull pin low");

    property p_mask_two;
        !q.ctl[rail_good_pkg::CTL_LINEAR_TWO_MASK] && !q.status[rail_good_pkg::STAT_LINEAR_TWO]
            |=> !rail_good_output;
    endproperty
    a_mask_two: assert property (p_mask_two) // [R6]
        else $error("unmasked low linear two did not pull pin low");

    property p_delay_met;
        $rose(rail_good_output) |-> good_run_q >= 32'(rail_good_pkg::delay_ms(
            q.ctl[rail_good_pkg::CTL_DELAY_MSB:rail_good_pkg::CTL_DELAY_LSB])) * ms_tick_cycles;
    endproperty
    a_delay_met: assert property (p_delay_met) // [R7]
        else $error("rail good pin rose before the selected delay");

    property p_control_reset;
        @(posedge clock) disable iff (1'b0)
        srst |=> reg_rdata == 8'h00 && {4'h0, q.ctl} == rail_good_pkg::CONTROL_RESET;
    endproperty
    a_control_reset: assert property (p_control_reset) // [R8]
        else $error("control register not at reset value");

    property p_locked_write;
        reg_wr && !unlocked && reg_addr == rail_good_pkg::ADDR_RAIL_GOOD_CONTROL
            |=> $stable(q.ctl);
    endproperty
    a_locked_write: assert property (p_locked_write) // [R9]
        else $error("control register changed while locked");

    property p_key_relock;
        xfer_end && !q.key_fresh && !(reg_wr && reg_addr == rail_good_pkg::ADDR_UNLOCK_KEY)
            |=> q.key == rail_good_pkg::KEY_CLEAR;
    endproperty
    a_key_relock: assert property (p_key_relock) // [R14]
        else $error("key not cleared after following transaction");

    property p_buck_ext_write;
        reg_wr && unlocked && reg_addr == rail_good_pkg::ADDR_BUCK_ONE_VOLTAGE_CONTROL
            |=> buck_one_external_adjust == $past(reg_wdata[rail_good_pkg::BUCK_EXT_BIT])
                && q.key == rail_good_pkg::KEY_CLEAR;
    endproperty
    a_buck_ext_write: assert property (p_buck_ext_write) // [R10] [R13]
        else $error("unlocked buck one write not taken or key kept");

    c_pin_rises: cover property ($rose(rail_good_output));
    c_protected_write: cover property (reg_wr && unlocked
        && reg_addr == rail_good_pkg::ADDR_RAIL_GOOD_CONTROL);
    c_relock: cover property (q.key == rail_good_pkg::UNLOCK_VALUE && xfer_end && !q.key_fresh);
endmodule

//--- test/host_model.sv
// host-side register master model driving decoded register cycles
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic clock,
    // register cycle outputs
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic xfer_end,
    // read data back
    input wire logic [7:0] reg_rdata
);
    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        xfer_end = 1'b0;
    end

    // one-byte write that closes its own transaction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        xfer_end <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // released data keeps no stale value
        xfer_end <= 1'b0;
    endtask

    // key transaction then the protected write, as each control or buck-one write needs
    task automatic prot_wr(input logic [7:0] a, input logic [7:0] d);
        wr(rail_good_pkg::ADDR_UNLOCK_KEY, rail_good_pkg::UNLOCK_VALUE);
        wr(a, d);
    endtask

    // one-byte read, data taken after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        xfer_end <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        xfer_end <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

//--- test/testbench.sv
// self-checking bench for the rail-good and buck-one register slice
`timescale 1ns/100ps
module testbench;
    localparam int unsigned tick = 10;
    localparam logic [7:0] a_st = rail_good_pkg::ADDR_RAIL_GOOD_STATUS;
    localparam logic [7:0] a_ct = rail_good_pkg::ADDR_RAIL_GOOD_CONTROL;
    localparam logic [7:0] a_bk = rail_good_pkg::ADDR_BUCK_ONE_VOLTAGE_CONTROL;
    localparam logic [7:0] a_key = rail_good_pkg::ADDR_UNLOCK_KEY;
    logic clock, srst, reg_wr, reg_rd, xfer_end, pin, ext;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got, d;
    logic [5:0] code;
    logic [8:0] rails;
    logic [31:0] seed = 32'h0000_0060;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int ms[4] = '{20, 100, 200, 400};

    rail_good_regs #(.ms_tick_cycles(tick)) i_rail_good_regs (
        .clock(clock), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .xfer_end(xfer_end), .linear_four_is_switch(rails[8]),
        .linear_three_is_switch(rails[7]), .linear_three_good(rails[6]),
        .linear_four_good(rails[5]), .buck_one_good(rails[4]), .buck_two_good(rails[3]),
        .buck_three_good(rails[2]), .linear_one_good(rails[1]),
        .linear_two_good(rails[0]), .rail_good_output(pin),
        .buck_one_external_adjust(ext), .buck_one_voltage_code(code)
    );
    host_model i_host_model (
        .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .xfer_end(xfer_end), .reg_rdata(reg_rdata)
    );

    // xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // status byte expected from the rail vector
    function automatic logic [7:0] exp_status(input logic [8:0] r);
        return {1'b0, r[6] | r[7], r[5] | r[8], r[4:0]};
    endfunction

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_host_model.rd(a, got);
        chk(got, e);
    endtask
    // change rails and let them pass the synchroniser
    task automatic set_rails(input logic [8:0] r);
        @(posedge clock);
        rails <= r;
        repeat (5) @(posedge clock);
    endtask
    task automatic wait_pin(input logic v, input int lim);
        for (int n = 0; n < lim && pin !== v; n++) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            close_out();
        end
    end

    // main sequence
    initial begin
        srst = 1'b1;
        rails = 9'h000;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        rchk(a_st, rail_good_pkg::STATUS_RESET);
        rchk(a_ct, 8'h0C);
        rchk(a_bk, {2'b00, rail_good_pkg::BUCK_CODE_DEFAULT});
        chk({ext, 1'b0, code}, {2'b00, rail_good_pkg::BUCK_CODE_DEFAULT});
        rchk(a_key, 8'h00);
        $display("test reset_values done");
        // refused writes: locked, read-only, unmapped, then one unlocked write and relock
        i_host_model.wr(a_ct, 8'h01);
        rchk(a_ct, 8'h0C);
        i_host_model.wr(a_st, 8'hFF);
        rchk(a_st, 8'h00);
        i_host_model.wr(8'h3F, 8'h55);
        rchk(8'h3F, 8'h00);
        i_host_model.prot_wr(a_ct, 8'hF1);
        rchk(a_ct, 8'h01);
        rchk(a_key, 8'h00);
        i_host_model.wr(a_ct, 8'h02);
        rchk(a_ct, 8'h01);
        i_host_model.wr(a_key, rail_good_pkg::UNLOCK_VALUE);
        rchk(a_key, rail_good_pkg::UNLOCK_VALUE);
        i_host_model.wr(a_ct, 8'h03);
        rchk(a_ct, 8'h01);
        $display("test lock done");
        // random buck-one settings, external adjust both ways
        for (int i = 0; i < 4; i++) begin
            d = 8'(rnd());
            d[7] = i[0];
            i_host_model.prot_wr(a_bk, d);
            rchk(a_bk, {d[7], 1'b0, d[5:0]});
            chk({ext, 1'b0, code}, {d[7], 1'b0, d[5:0]});
        end
        i_host_model.wr(a_key, 8'h7C);
        i_host_model.wr(a_bk, 8'h00);
        rchk(a_bk, {d[7], 1'b0, d[5:0]});
        $display("test buck_one done");
        // status from random rails, switch-only corner first
        for (int i = 0; i < 10; i++) begin
            set_rails(i == 0 ? 9'h180 : 9'(rnd()));
            rchk(a_st, exp_status(rails));
        end
        $display("test status done");
        // pin delay for every select code
        for (int s = 0; s < 4; s++) begin
            i_host_model.prot_wr(a_ct, {6'h03, s[1:0]});
            set_rails(9'h000);
            set_rails(9'h07F);
            repeat (ms[s] * tick - 10) @(posedge clock);
            #1;
            chk({7'h00, pin}, 8'h00);
            wait_pin(1'b1, ms[s] + 40);
            chk({7'h00, pin}, 8'h01);
        end
        $display("test delay done");
        // masking of linear one and two
        set_rails(9'h07C);
        chk({7'h00, pin}, 8'h01);
        i_host_model.prot_wr(a_ct, 8'h04);
        wait_pin(1'b0, 4);
        chk({7'h00, pin}, 8'h00);
        set_rails(9'h07E);
        wait_pin(1'b1, 260);
        chk({7'h00, pin}, 8'h01);
        i_host_model.prot_wr(a_ct, 8'h08);
        wait_pin(1'b0, 4);
        chk({7'h00, pin}, 8'h00);
        set_rails(9'h07F);
        wait_pin(1'b1, 260);
        chk({7'h00, pin}, 8'h01);
        set_rails(9'h06F);
        @(posedge clock);
        #1;
        chk({7'h00, pin}, 8'h00);
        $display("test mask done");
        close_out();
    end
endmodule
